//--- pkg/fhl_pkg.sv
// Register map, header field layout and decode codes for the header/mix bank
package fhl_pkg;
   // Byte addresses on the control bus
   localparam logic [7:0] FHL_ADDR_ANC_HIGH = 8'h42;
   localparam logic [7:0] FHL_ADDR_HEAD_UPPER = 8'h43;
   localparam logic [7:0] FHL_ADDR_HEAD_MIDDLE = 8'h44;
   localparam logic [7:0] FHL_ADDR_HEAD_LOWER = 8'h45;
   localparam logic [7:0] FHL_ADDR_LEFT_TRIM = 8'h46;
   localparam logic [7:0] FHL_ADDR_CROSSFEED = 8'h47;
   // Reset values, attenuation limit and mute code
   localparam logic [7:0] FHL_RST_RO = 8'h00;
   localparam logic [7:0] FHL_RST_LEFT_TRIM = 8'h00;
   localparam logic [7:0] FHL_RST_CROSSFEED = 8'hff;
   localparam logic [7:0] FHL_ATTEN_MAX_DB = 8'h60;
   localparam logic [7:0] FHL_ATTEN_MUTE_CODE = 8'hff;
   // Header field positions
   localparam int FHL_HEAD_W = 21;
   localparam int FHL_EMPH_LO = 0;
   localparam int FHL_ORIG_BIT = 2;
   localparam int FHL_COPYR_BIT = 3;
   localparam int FHL_MODEX_LO = 4;
   localparam int FHL_MODE_LO = 6;
   localparam int FHL_PRIV_BIT = 8;
   localparam int FHL_PAD_BIT = 9;
   localparam int FHL_SFREQ_LO = 10;
   localparam int FHL_RATE_LO = 12;
   localparam int FHL_PROT_BIT = 16;
   localparam int FHL_LAYER_LO = 17;
   localparam int FHL_VER_BIT = 19;
   localparam int FHL_VEREXT_BIT = 20;
   // Field codes
   localparam logic [1:0] FHL_LAYER_III = 2'h1;
   localparam logic [3:0] FHL_RATE_FREE = 4'h0;
   localparam logic [3:0] FHL_RATE_BAD = 4'hf;
   localparam logic [1:0] FHL_SFREQ_RSVD = 2'h3;
   localparam logic [1:0] FHL_EMPH_RSVD = 2'h2;
   localparam logic [1:0] FHL_MODE_JOINT = 2'h1;
   localparam logic [1:0] FHL_MODE_MONO = 2'h3;
   typedef enum logic [1:0] {
      FHL_MPEG25, FHL_MPEG_RSVD, FHL_MPEG2, FHL_MPEG1
   } fhl_version_e;
endpackage

//--- rtl/fhl_header_decode.sv
// Combinational decode of the captured frame header into its fields
`timescale 1ns/100ps
module fhl_header_decode
   import fhl_pkg::*;
(
   input wire logic [20:0] head_in,
   output fhl_version_e version_out,
   output logic [8:0] bitrate_kbps_out,
   output logic [1:0] sfreq_idx_out,
   output logic [1:0] mode_out,
   output logic [1:0] modex_out,
   output logic [1:0] emph_out,
   output logic crc_present_out,
   output logic layer_ok_out,
   output logic header_bad_out,
   output logic padded_out,
   output logic copyr_out,
   output logic orig_out,
   output logic priv_out
);
   logic [3:0] rate_idx;

   // Bitrate tables per version flag
   function automatic logic [8:0] fhl_rate(input logic ver,
                                           input logic [3:0] idx);
      logic [8:0] r;
      r = 9'h000;
      if (ver) begin
         case (idx)
            4'h1: r = 9'h020;
            4'h2: r = 9'h028;
            4'h3: r = 9'h030;
            4'h4: r = 9'h038;
            4'h5: r = 9'h040;
            4'h6: r = 9'h050;
            4'h7: r = 9'h060;
            4'h8: r = 9'h070;
            4'h9: r = 9'h080;
            4'ha: r = 9'h0a0;
            4'hb: r = 9'h0c0;
            4'hc: r = 9'h0e0;
            4'hd: r = 9'h100;
            4'he: r = 9'h140;
            default: r = 9'h000;
         endcase
      end else begin
         case (idx)
            4'h1: r = 9'h008;
            4'h2: r = 9'h010;
            4'h3: r = 9'h018;
            4'h4: r = 9'h020;
            4'h5: r = 9'h028;
            4'h6: r = 9'h030;
            4'h7: r = 9'h038;
            4'h8: r = 9'h040;
            4'h9: r = 9'h050;
            4'ha: r = 9'h060;
            4'hb: r = 9'h070;
            4'hc: r = 9'h080;
            4'hd: r = 9'h090;
            4'he: r = 9'h0a0;
            default: r = 9'h000;
         endcase
      end
      return r;
   endfunction

   // Field extraction
   always_comb begin
      rate_idx = head_in[FHL_RATE_LO +: 4];
      version_out = fhl_version_e'({head_in[FHL_VEREXT_BIT],
                                    head_in[FHL_VER_BIT]});
      // Free and forbidden codes give zero rate
      bitrate_kbps_out = fhl_rate(head_in[FHL_VER_BIT], rate_idx);
      sfreq_idx_out = head_in[FHL_SFREQ_LO +: 2];
      mode_out = head_in[FHL_MODE_LO +: 2];
      // Extension only carries meaning in joint stereo
      modex_out = (mode_out == FHL_MODE_JOINT) ?
                  head_in[FHL_MODEX_LO +: 2] : 2'h0;
      emph_out = head_in[FHL_EMPH_LO +: 2];
      crc_present_out = ~head_in[FHL_PROT_BIT];
      layer_ok_out = head_in[FHL_LAYER_LO +: 2] == FHL_LAYER_III;
      header_bad_out = (rate_idx == FHL_RATE_BAD) |
                       (sfreq_idx_out == FHL_SFREQ_RSVD) |
                       (version_out == FHL_MPEG_RSVD) |
                       (emph_out == FHL_EMPH_RSVD) | ~layer_ok_out;
      padded_out = head_in[FHL_PAD_BIT];
      copyr_out = head_in[FHL_COPYR_BIT];
      orig_out = head_in[FHL_ORIG_BIT];
      priv_out = head_in[FHL_PRIV_BIT];
   end
endmodule

//--- rtl/fhl_regs.sv
// Header capture, ancillary count and left-channel mix register bank
`timescale 1ns/100ps
module fhl_regs
   import fhl_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic soft_rst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic frame_sync_in,
   input wire logic [20:0] frame_header_in,
   input wire logic frame_good_in,
   input wire logic [15:0] anc_count_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_hit_out,
   output logic [7:0] left_atten_db_out,
   output logic left_full_mute_out,
   output logic [7:0] crossfeed_db_out,
   output logic crossfeed_off_out,
   output logic [1:0] version_out,
   output logic [8:0] bitrate_kbps_out,
   output logic [1:0] sfreq_idx_out,
   output logic [1:0] mode_out,
   output logic [1:0] modex_out,
   output logic [1:0] emph_out,
   output logic crc_present_out,
   output logic header_bad_out,
   output logic padded_out
);
   logic [20:0] head_reg;
   logic [15:0] anc_reg;
   logic [7:0] left_trim_reg;
   logic [7:0] crossfeed_reg;
   logic [7:0] rdata_next;
   logic hit_next;
   fhl_version_e dec_version;
   logic [8:0] dec_rate;
   logic [1:0] dec_sfreq;
   logic [1:0] dec_mode;
   logic [1:0] dec_modex;
   logic [1:0] dec_emph;
   logic dec_crc;
   logic dec_layer_ok;
   logic dec_bad;
   logic dec_pad;

   // Attenuation code to effective dB, saturating beyond the table
   function automatic logic [7:0] fhl_atten(input logic [7:0] code);
      return (code > FHL_ATTEN_MAX_DB) ? FHL_ATTEN_MUTE_CODE : code;
   endfunction

   // Header decode of the captured value
   fhl_header_decode u_decode (
      .head_in(head_reg),
      .version_out(dec_version),
      .bitrate_kbps_out(dec_rate),
      .sfreq_idx_out(dec_sfreq),
      .mode_out(dec_mode),
      .modex_out(dec_modex),
      .emph_out(dec_emph),
      .crc_present_out(dec_crc),
      .layer_ok_out(dec_layer_ok),
      .header_bad_out(dec_bad),
      .padded_out(dec_pad),
      .copyr_out(),
      .orig_out(),
      .priv_out()
   );

   // Header capture, whole word at once so bytes never mix frames
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         head_reg <= 21'h000000;
      end else if (soft_rst_in) begin
         head_reg <= 21'h000000;
      end else if (frame_sync_in) begin
         head_reg <= frame_header_in;
      end
   end

   // Ancillary count, only refreshed by correctly decoded frames
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         anc_reg <= 16'h0000;
      end else if (soft_rst_in) begin
         anc_reg <= 16'h0000;
      end else if (frame_good_in) begin
         anc_reg <= anc_count_in;
      end
   end

   // Software-writable mix registers; read-only addresses not decoded
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         left_trim_reg <= FHL_RST_LEFT_TRIM;
         crossfeed_reg <= FHL_RST_CROSSFEED;
      end else if (soft_rst_in) begin
         left_trim_reg <= FHL_RST_LEFT_TRIM;
         crossfeed_reg <= FHL_RST_CROSSFEED;
      end else if (reg_wr_in) begin
         if (reg_addr_in == FHL_ADDR_LEFT_TRIM) begin
            left_trim_reg <= reg_wdata_in;
         end
         if (reg_addr_in == FHL_ADDR_CROSSFEED) begin
            crossfeed_reg <= reg_wdata_in;
         end
      end
   end

   // Read mux; upper header byte pads top bits with zero
   always_comb begin
      rdata_next = FHL_RST_RO;
      hit_next = 1'b1;
      case (reg_addr_in)
         FHL_ADDR_ANC_HIGH: rdata_next = anc_reg[15:8];
         FHL_ADDR_HEAD_UPPER: rdata_next = {3'h0, head_reg[20:16]};
         FHL_ADDR_HEAD_MIDDLE: rdata_next = head_reg[15:8];
         FHL_ADDR_HEAD_LOWER: rdata_next = head_reg[7:0];
         FHL_ADDR_LEFT_TRIM: rdata_next = left_trim_reg;
         FHL_ADDR_CROSSFEED: rdata_next = crossfeed_reg;
         default: hit_next = 1'b0;
      endcase
   end

   // Registered read data, held between reads
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= FHL_RST_RO;
         reg_hit_out <= 1'b0;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_next;
         reg_hit_out <= hit_next;
      end
   end

   // Effective attenuation toward the mix datapath
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         left_atten_db_out <= FHL_ATTEN_MUTE_CODE;
         left_full_mute_out <= 1'b0;
         crossfeed_db_out <= FHL_ATTEN_MUTE_CODE;
         crossfeed_off_out <= 1'b1;
      end else begin
         left_atten_db_out <= fhl_atten(left_trim_reg);
         left_full_mute_out <= left_trim_reg > FHL_ATTEN_MAX_DB;
         crossfeed_db_out <= fhl_atten(crossfeed_reg);
         crossfeed_off_out <= crossfeed_reg > FHL_ATTEN_MAX_DB;
      end
   end

   // Registered header field view
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         version_out <= 2'h0;
         bitrate_kbps_out <= 9'h000;
         sfreq_idx_out <= 2'h0;
         mode_out <= 2'h0;
         modex_out <= 2'h0;
         emph_out <= 2'h0;
         crc_present_out <= 1'b0;
         header_bad_out <= 1'b0;
         padded_out <= 1'b0;
      end else begin
         version_out <= dec_version;
         bitrate_kbps_out <= dec_rate;
         sfreq_idx_out <= dec_sfreq;
         mode_out <= dec_mode;
         modex_out <= dec_modex;
         emph_out <= dec_emph;
         crc_present_out <= dec_crc;
         // Reset header of zero is not a real frame
         header_bad_out <= dec_bad & (head_reg != 21'h000000);
         padded_out <= dec_pad;
      end
   end

   // Capture lands one cycle after the sync strobe
   head_capture_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      frame_sync_in && !soft_rst_in |=> head_reg == $past(frame_header_in))
      else $error("header not captured on sync");

   // Header holds without sync
   head_hold_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !frame_sync_in && !soft_rst_in |=> $stable(head_reg))
      else $error("header changed without sync");

   // Top byte pad bits read zero
   upper_pad_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      reg_rd_in && reg_addr_in == FHL_ADDR_HEAD_UPPER
      |=> reg_rdata_out[7:5] == 3'h0)
      else $error("upper header pad bits set");

   // Count high byte read back
   anc_read_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      reg_rd_in && reg_addr_in == FHL_ADDR_ANC_HIGH && !frame_good_in
      && !soft_rst_in |=> reg_rdata_out == anc_reg[15:8])
      else $error("count high byte wrong");

   // Writes to read-only space leave count alone
   ro_write_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      reg_wr_in && !frame_good_in && !soft_rst_in |=> $stable(anc_reg))
      else $error("count changed by write");

   // Left trim write reaches the mix output two cycles on
   trim_write_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      reg_wr_in && reg_addr_in == FHL_ADDR_LEFT_TRIM && !soft_rst_in
      && reg_wdata_in <= FHL_ATTEN_MAX_DB
      ##1 !(reg_wr_in && reg_addr_in == FHL_ADDR_LEFT_TRIM) && !soft_rst_in
      |=> left_atten_db_out == $past(reg_wdata_in, 2))
      else $error("left trim not applied");

   // Maximum code mutes left
   trim_max_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      left_trim_reg == FHL_ATTEN_MUTE_CODE |=> left_full_mute_out)
      else $error("left max code not muted");

   // Crossfeed defaults fully off after soft reset
   xfeed_reset_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      soft_rst_in ##1 !reg_wr_in |=> crossfeed_off_out)
      else $error("crossfeed not off after reset");

   // Protection bit inverted into crc flag; first edge out of reset skipped
   crc_flag_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !$past(rst_in) |-> crc_present_out == !$past(head_reg[FHL_PROT_BIT]))
      else $error("crc flag mismatch");

   // Mode extension masked outside joint stereo
   modex_mask_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      mode_out != FHL_MODE_JOINT |-> modex_out == 2'h0)
      else $error("mode extension outside joint");

   // Soft reset restores the mix registers
   soft_mix_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      soft_rst_in |=> left_trim_reg == FHL_RST_LEFT_TRIM
      && crossfeed_reg == FHL_RST_CROSSFEED)
      else $error("mix registers not restored");

   // Count taken from a good frame
   anc_capture_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      frame_good_in && !soft_rst_in |=> anc_reg == $past(anc_count_in))
      else $error("count not captured");

   // Count holds between good frames
   anc_hold_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !frame_good_in && !soft_rst_in |=> $stable(anc_reg))
      else $error("count changed without good frame");

   // Low header byte read back
   head_lower_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      reg_rd_in && reg_addr_in == FHL_ADDR_HEAD_LOWER && !frame_sync_in
      && !soft_rst_in |=> reg_rdata_out == head_reg[7:0])
      else $error("low header byte wrong");

   // Left trim read back
   trim_read_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      reg_rd_in && reg_addr_in == FHL_ADDR_LEFT_TRIM && !reg_wr_in
      && !soft_rst_in |=> reg_rdata_out == left_trim_reg)
      else $error("left trim read wrong");

   // Crossfeed write lands next cycle
   xfeed_write_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      reg_wr_in && reg_addr_in == FHL_ADDR_CROSSFEED && !soft_rst_in
      |=> crossfeed_reg == $past(reg_wdata_in))
      else $error("crossfeed write lost");

   // Crossfeed at its top code cuts the path
   xfeed_max_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      crossfeed_reg == FHL_ATTEN_MUTE_CODE
      |=> crossfeed_off_out && crossfeed_db_out == FHL_ATTEN_MUTE_CODE)
      else $error("crossfeed not off at top code");

   // Codes past the table saturate left
   trim_mute_db_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      left_trim_reg > FHL_ATTEN_MAX_DB
      |=> left_atten_db_out == FHL_ATTEN_MUTE_CODE)
      else $error("left code not saturated");

   // Table codes pass through in 1 dB steps
   trim_pass_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      left_trim_reg <= FHL_ATTEN_MAX_DB
      |=> left_atten_db_out == $past(left_trim_reg) && !left_full_mute_out)
      else $error("left code not passed");

   // Version pair follows the captured flags
   version_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !$past(rst_in) |-> version_out == $past(head_reg[FHL_VER_BIT +: 2]))
      else $error("version pair mismatch");

   // Wrong layer marks the header bad
   layer_ok_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !dec_layer_ok && head_reg != 21'h000000 |=> header_bad_out)
      else $error("wrong layer not flagged");

   // Forbidden bitrate flagged and given no rate
   rate_bad_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      head_reg[FHL_RATE_LO +: 4] == FHL_RATE_BAD
      |=> header_bad_out && bitrate_kbps_out == 9'h000)
      else $error("forbidden bitrate not flagged");

   // Padding bit passed through
   pad_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      !$past(rst_in) |-> padded_out == $past(head_reg[FHL_PAD_BIT]))
      else $error("padding flag mismatch");

   // Reserved emphasis flagged
   emph_rsvd_a: assert property (
      @(posedge sys_clk_in) disable iff (rst_in)
      head_reg[FHL_EMPH_LO +: 2] == FHL_EMPH_RSVD |=> header_bad_out)
      else $error("reserved emphasis not flagged");
endmodule

//--- sim/fhl_host_model.sv
// Host side of the register strobe bus, driving on the falling edge
`timescale 1ns/100ps
module fhl_host_model (
   input wire logic sys_clk_in,
   input wire logic [7:0] reg_rdata_in,
   input wire logic reg_hit_in,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out
);
   // Bus quiet at time zero
   initial begin
      put(1'b0, 1'b0, 8'h00, 8'h00);
   end

   // Every bus line in one place
   task automatic put(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
      reg_wr_out = w;
      reg_rd_out = r;
      reg_addr_out = a;
      reg_wdata_out = d;
   endtask

   // Write held through one rising edge; strobe stays up for bursts
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk_in);
      put(1'b1, 1'b0, a, d);
      @(posedge sys_clk_in);
   endtask

   // Released lines flip so stale values never look valid
   task automatic idle();
      @(negedge sys_clk_in);
      put(1'b0, 1'b0, ~reg_addr_out, ~reg_wdata_out);
   endtask

   // Read data sampled a full cycle later, since it stands until next read
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic h);
      @(negedge sys_clk_in);
      put(1'b0, 1'b1, a, ~reg_wdata_out);
      @(posedge sys_clk_in);
      idle();
      @(negedge sys_clk_in);
      d = reg_rdata_in;
      h = reg_hit_in;
   endtask
endmodule

//--- sim/test_frame_header_and_left_mix_regs.sv
// Self-checking bench for the header capture and left mix register bank
`timescale 1ns/100ps
module test_frame_header_and_left_mix_regs
   import fhl_pkg::*;
;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic soft_rst_in = 1'b0;
   logic frame_sync_in = 1'b0;
   logic frame_good_in = 1'b0;
   logic [20:0] frame_header_in = 21'h0;
   logic [15:0] anc_count_in = 16'h0;
   logic reg_wr, reg_rd, reg_hit, l_mute, x_off, crc, bad, pad;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, l_att, x_att;
   logic [1:0] ver, sfreq, mode, modex, emph;
   logic [8:0] kbps;
   logic [20:0] m_hdr, h;
   logic [15:0] m_anc;
   logic [7:0] m_trim, m_xf;
   logic [7:0] codes [8];
   int n_mismatch = 0;
   int compares = 0;
   int rate1 [16] = '{0, 32, 40, 48, 56, 64, 80, 96, 112, 128, 160, 192,
                      224, 256, 320, 0};
   int rate0 [16] = '{0, 8, 16, 24, 32, 40, 48, 56, 64, 80, 96, 112,
                      128, 144, 160, 0};
   wire logic [39:0] dut_hdr = {18'h0, ver, kbps, sfreq, mode, modex, emph,
                                crc, bad, pad};
   wire logic [39:0] dut_mix = {22'h0, l_att, l_mute, x_att, x_off};

   // 250 MHz system clock
   initial begin
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   fhl_regs u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .soft_rst_in(soft_rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .frame_sync_in(frame_sync_in), .frame_header_in(frame_header_in),
      .frame_good_in(frame_good_in), .anc_count_in(anc_count_in),
      .reg_rdata_out(reg_rdata), .reg_hit_out(reg_hit),
      .left_atten_db_out(l_att), .left_full_mute_out(l_mute),
      .crossfeed_db_out(x_att), .crossfeed_off_out(x_off),
      .version_out(ver), .bitrate_kbps_out(kbps), .sfreq_idx_out(sfreq),
      .mode_out(mode), .modex_out(modex), .emph_out(emph),
      .crc_present_out(crc), .header_bad_out(bad), .padded_out(pad));

   fhl_host_model u_host (.sys_clk_in(sys_clk_in), .reg_rdata_in(reg_rdata),
      .reg_hit_in(reg_hit), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
      .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata));

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (n_mismatch == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Codes past 96 dB all mean the fully attenuated path
   function automatic logic [7:0] att(input logic [7:0] c);
      return (c > 8'h60) ? 8'hff : c;
   endfunction

   function automatic logic [39:0] exp_hdr();
      logic [3:0] r;
      logic [8:0] br;
      logic b;
      r = m_hdr[15:12];
      br = 9'(m_hdr[19] ? rate1[r] : rate0[r]);
      b = r == 4'hf || m_hdr[11:10] == 2'h3 || m_hdr[20:19] == 2'h1;
      b = b || m_hdr[1:0] == 2'h2 || m_hdr[18:17] != 2'h1;
      return {18'h0, m_hdr[20:19], br, m_hdr[11:10], m_hdr[7:6],
         (m_hdr[7:6] == 2'h1) ? m_hdr[5:4] : 2'h0, m_hdr[1:0],
         ~m_hdr[16], b && m_hdr != 21'h0, m_hdr[9]};
   endfunction

   function automatic logic [8:0] rd_exp(input logic [7:0] a);
      case (a)
         FHL_ADDR_ANC_HIGH: return {m_anc[15:8], 1'b1};
         FHL_ADDR_HEAD_UPPER: return {3'h0, m_hdr[20:16], 1'b1};
         FHL_ADDR_HEAD_MIDDLE: return {m_hdr[15:8], 1'b1};
         FHL_ADDR_HEAD_LOWER: return {m_hdr[7:0], 1'b1};
         FHL_ADDR_LEFT_TRIM: return {m_trim, 1'b1};
         FHL_ADDR_CROSSFEED: return {m_xf, 1'b1};
         default: return 9'h0;
      endcase
   endfunction

   task automatic model_reset();
      m_hdr = 21'h0;
      m_anc = 16'h0;
      m_trim = 8'h00;
      m_xf = 8'hff;
   endtask

   // Decoded outputs, then every mapped byte plus one each side
   task automatic check_all();
      logic [7:0] d;
      logic hit;
      repeat (3) @(negedge sys_clk_in);
      chk(dut_hdr, exp_hdr());
      chk(dut_mix, {22'h0, att(m_trim), m_trim > 8'h60,
          att(m_xf), m_xf > 8'h60});
      for (int a = 8'h41; a < 8'h49; a++) begin
         u_host.rd(8'(a), d, hit);
         chk(40'({d, hit}), 40'(rd_exp(8'(a))));
      end
   endtask

   // Sync and good pulses are independent, as the decoder raises them
   task automatic frame(input logic [20:0] hv, input logic [15:0] n,
                        input logic s, input logic g);
      @(negedge sys_clk_in);
      frame_header_in = hv;
      anc_count_in = n;
      frame_sync_in = s;
      frame_good_in = g;
      @(negedge sys_clk_in);
      frame_sync_in = 1'b0;
      frame_good_in = 1'b0;
      frame_header_in = ~hv;
      anc_count_in = ~n;
      if (s) m_hdr = hv;
      if (g) m_anc = n;
   endtask

   // Hang guard
   initial begin
      #100000;
      n_mismatch++;
      final_report();
   end

   initial begin
      model_reset();
      repeat (20) @(negedge sys_clk_in);
      rst_in = 1'b0;
      void'($urandom(73972));
      check_all();
      // First sixteen frames walk every version, layer, frequency, mode and emphasis code; rate codes 1, 4, 7, 10 and 13 come without sync and are not captured
      for (int i = 0; i < 40; i++) begin
         h = 21'($urandom);
         if (i < 16) h = {2'(i), 2'(i >> 2), h[16], 4'(i), 2'(i), h[9:8],
                          2'(i), h[5:2], 2'(i)};
         frame(h, 16'($urandom), i % 3 != 1, i % 3 != 2);
         check_all();
      end
      // Back-to-back writes to read-only and unmapped places
      for (int a = 8'h42; a < 8'h46; a++) u_host.wr(8'(a), 8'($urandom));
      u_host.wr(8'h48, 8'($urandom));
      u_host.idle();
      check_all();
      codes = '{8'h00, 8'h01, 8'h5f, 8'h60, 8'h61, 8'hfe, 8'hff,
                8'($urandom)};
      for (int k = 0; k < 8; k++) begin
         u_host.wr(FHL_ADDR_LEFT_TRIM, codes[k]);
         u_host.wr(FHL_ADDR_CROSSFEED, codes[7 - k]);
         u_host.idle();
         m_trim = codes[k];
         m_xf = codes[7 - k];
         check_all();
      end
      // Soft reset wins over a capture and a write in the same cycles
      @(negedge sys_clk_in);
      soft_rst_in = 1'b1;
      frame(21'h1a5a5a, 16'h1234, 1'b1, 1'b1);
      u_host.wr(FHL_ADDR_CROSSFEED, 8'h33);
      u_host.idle();
      soft_rst_in = 1'b0;
      model_reset();
      check_all();
      frame(21'h0b7e31, 16'hbeef, 1'b1, 1'b1);
      check_all();
      // Hardware reset in mid-run
      rst_in = 1'b1;
      repeat (3) @(negedge sys_clk_in);
      rst_in = 1'b0;
      model_reset();
      check_all();
      final_report();
   end
endmodule
